// ---- i2c_recv_wait_timeout_ctrl.sv ----
// Top of the two-wire bus control extension: registers, wait stall, pin override
//
// Summary of operation
// - Receive wait raises interrupt after last data bit
// - After restart, interrupt again at acknowledge fall
// - Wait enable reads internal wait flag
// - Transmit or address byte: flag stays zero
// - Data override drives port latch on pin
// - Clock override drives port latch on pin
// - Software reads real line levels always
// - Monitor bits show internal driver levels, not override levels, read-only
// - Five-bit select picks bus clock divide ratio
// - Source select picks full or half clock
// - Works in wait mode unless clock stopped
// - Busy, clock high for period: time-out
// - Overflow sets flag and interrupt together
// - Counter is 16 bits long, 14 short
// - Request bit low holds clock line low
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module i2c_recv_wait_timeout_ctrl
(
   input  wire logic        clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // State from the start/stop and direction logic on the same clock
   input  wire logic        bus_busy_flag,
   input  wire logic        transmit_mode,
   input  wire logic        address_phase,
   // Power mode
   input  wire logic        wait_mode,
   input  wire logic        wait_clock_stop,
   // Bus pins, open drain
   input  wire logic        data_line_i,
   output logic             data_line_o,
   output logic             data_line_oe,
   input  wire logic        clock_line_i,
   output logic             clock_line_o,
   output logic             clock_line_oe,
   // Bus interrupt, one-cycle pulse
   output logic             bus_irq
);
   import i2c_ext_pkg::*;

   // Shared carrier to the divider and the time-out counter
   i2c_ext_if ctl ();

   logic [7:0]  ctrl_one_q;
   logic [7:0]  ctrl_two_q;
   logic [7:0]  shift_q;
   logic [7:0]  ack_q;
   logic [3:0]  mode_q;
   logic        req_q;       // Interrupt request bit, 0 while a request stands
   logic        wait_flag_q;
   logic        tof_q;
   logic        irq_q;
   logic [3:0]  bit_cnt_q;
   logic [1:0]  sda_sync_q;
   logic [1:0]  scl_sync_q;
   logic        scl_prev_q;
   logic [31:0] rdata_q;
   logic        ready_q;
   logic        err_q;
   logic        sda_o_q;
   logic        sda_oe_q;
   logic        scl_o_q;
   logic        scl_oe_q;
   logic        sda_int;
   logic        scl_int;
   logic        enabled;
   logic        run;
   logic        wr_fire;
   logic        rd_take;
   logic        scl_fall;
   logic        wait_eff;
   logic        last_data_fall;
   logic        ack_fall;
   logic        stall_evt;
   logic        done_evt;
   logic        mapped;
   logic [7:0]  ctrl_one_rd;
   logic [3:0]  status_rd;

   // Decode used by read mux, write strobes and error answer
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ==========================================================
   // Control wiring
   assign enabled = mode_q[MD_ENABLE];
   // No clock means no operation when the peripheral clock stops in wait mode
   assign run     = enabled && !(wait_mode && wait_clock_stop);
   assign mapped  = hit(paddr, CTRL_ONE_OFS) || hit(paddr, CTRL_TWO_OFS) ||
                    hit(paddr, SHIFT_OFS) || hit(paddr, ACK_OFS) ||
                    hit(paddr, MODE_OFS) || hit(paddr, STATUS_OFS);
   assign wr_fire = psel && penable && ready_q && pwrite;
   assign rd_take = psel && penable && !ready_q && !pwrite;

   // Divider and time-out controls; the counter sees only the synchronised clock
   assign ctl.div_sel   = {ctrl_two_q[C2_DIV_HI+2:C2_DIV_HI], ctrl_one_q[C1_DIV_LO+1:C1_DIV_LO]};
   assign ctl.src_sel   = mode_q[MD_SRC_SEL];
   assign ctl.run       = run;
   assign ctl.tmo_en    = ctrl_two_q[C2_TMO_EN];
   assign ctl.tmo_short = ctrl_two_q[C2_TMO_SHORT];
   assign ctl.busy      = bus_busy_flag;
   assign ctl.scl_high  = scl_sync_q[1];

   // Bus system clock as a tick pulse
   i2c_clk_div u_div
   (
      .clk  (clk),
      .srst (srst),
      .ctl  (ctl)
   );

   // Stuck-high clock detector
   i2c_timeout u_tmo
   (
      .clk  (clk),
      .srst (srst),
      .ctl  (ctl)
   );

   // ==========================================================
   // Pin synchronisers; only the second stage is read
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sda_sync_q <= 2'b11;
         scl_sync_q <= 2'b11;
         scl_prev_q <= 1'b1;
      end
      else
      begin
         sda_sync_q <= {sda_sync_q[0], data_line_i};
         scl_sync_q <= {scl_sync_q[0], clock_line_i};
         scl_prev_q <= scl_sync_q[1];
      end
   end

   // A frozen block sees no clock falls at all
   assign scl_fall = run && scl_prev_q && !scl_sync_q[1];

   // ==========================================================
   // Bit clock counter, 1..8 data, 9 acknowledge
   always_ff @(posedge clk)
   begin
      if (srst || !run || !bus_busy_flag)
         bit_cnt_q <= 4'h0;
      else if (scl_fall)
         bit_cnt_q <= (bit_cnt_q == ACK_BIT) ? 4'h1 : 4'(bit_cnt_q + 4'h1);
   end

   // Transmit and address bytes never wait, whatever the enable says
   assign wait_eff = wait_flag_q && !transmit_mode && !address_phase;
   assign last_data_fall = scl_fall && (bit_cnt_q == LAST_DATA_BIT - 4'h1);
   assign ack_fall = scl_fall && (bit_cnt_q == LAST_DATA_BIT) && ack_q[ACK_CLK_EN];
   // Stall before the acknowledge clock only in receive-wait mode
   assign stall_evt = last_data_fall && ctrl_one_q[C1_WAIT_EN] && ack_q[ACK_CLK_EN] && wait_eff;
   // Without acknowledge clock the eighth clock is the last one
   assign done_evt = ack_fall || (last_data_fall && !ack_q[ACK_CLK_EN]);

   // ==========================================================
   // Interrupt request bit; the hardware clear wins over a software set
   always_ff @(posedge clk)
   begin
      if (srst || !enabled)
         req_q <= 1'b1;
      else if (run && (stall_evt || done_evt))
         req_q <= 1'b0;
      else if (wr_fire && hit(paddr, SHIFT_OFS))
         req_q <= 1'b1;
      else if (wr_fire && hit(paddr, STATUS_OFS) && pwdata[ST_REQ])
         req_q <= 1'b1;
      else if (wr_fire && hit(paddr, ACK_OFS) && ctrl_one_q[C1_WAIT_EN] && wait_flag_q)
         req_q <= 1'b1;
   end

   // Internal wait flag: shift write sets, acknowledge write clears
   always_ff @(posedge clk)
   begin
      if (srst || !enabled)
         wait_flag_q <= 1'b0;
      else if (wr_fire && hit(paddr, SHIFT_OFS))
         wait_flag_q <= 1'b1;
      else if (wr_fire && hit(paddr, ACK_OFS))
         wait_flag_q <= 1'b0;
   end

   // Time-out flag is sticky until disable; an overflow in that cycle wins
   always_ff @(posedge clk)
   begin
      if (srst)
         tof_q <= 1'b0;
      else if (ctl.overflow)
         tof_q <= 1'b1;
      else if (!enabled)
         tof_q <= 1'b0;
   end

   // One interrupt pulse per stall, byte end or time-out
   always_ff @(posedge clk)
   begin
      if (srst)
         irq_q <= 1'b0;
      else
         irq_q <= run && (stall_evt || done_evt || ctl.overflow);
   end

   // ==========================================================
   // Software-visible registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_one_q <= CTRL_ONE_RST;
         ctrl_two_q <= CTRL_TWO_RST;
         shift_q    <= 8'h00;
         ack_q      <= ACK_RST;
         mode_q     <= MODE_RST;
      end
      else if (wr_fire)
      begin
         if (hit(paddr, CTRL_ONE_OFS))
            ctrl_one_q <= pwdata[7:0];
         if (hit(paddr, CTRL_TWO_OFS))
            ctrl_two_q <= pwdata[7:0];
         if (hit(paddr, SHIFT_OFS))
            shift_q <= pwdata[7:0];
         if (hit(paddr, ACK_OFS))
            ack_q <= pwdata[7:0];
         if (hit(paddr, MODE_OFS))
            mode_q <= pwdata[3:0];
      end
   end

   // ==========================================================
   // Internal line drivers: clock held low while a request stands
   assign scl_int = !(enabled && !req_q);
   // Acknowledge bit is driven only during the acknowledge clock of a receive
   assign sda_int = !(enabled && !transmit_mode && ack_q[ACK_CLK_EN] &&
                      (bit_cnt_q == LAST_DATA_BIT) && req_q && !ack_q[ACK_LEVEL]);

   // Monitors show the internal drivers, so an override does not hide them
   assign ctrl_one_rd = {ctrl_one_q[7:6], scl_int, sda_int,
                         ctrl_one_q[C1_CLK_OVR:C1_DATA_OVR], wait_eff, ctrl_one_q[C1_STOP_IE]};

   // Line levels come from the synchronisers, whatever the pins are driven to
   assign status_rd = {scl_sync_q[1], sda_sync_q[1], bus_busy_flag, req_q};

   // Pin drivers; override replaces only the output, inputs stay connected
   always_ff @(posedge clk)
   begin
      if (srst || !enabled)
      begin
         sda_o_q  <= 1'b1;
         sda_oe_q <= 1'b0;
         scl_o_q  <= 1'b1;
         scl_oe_q <= 1'b0;
      end
      else
      begin
         if (ctrl_one_q[C1_DATA_OVR])
         begin
            sda_o_q  <= mode_q[MD_DLATCH];
            sda_oe_q <= 1'b1;
         end
         else
         begin
            sda_o_q  <= 1'b0;
            sda_oe_q <= !sda_int;
         end
         if (ctrl_one_q[C1_CLK_OVR])
         begin
            scl_o_q  <= mode_q[MD_CLATCH];
            scl_oe_q <= 1'b1;
         end
         else
         begin
            scl_o_q  <= 1'b0;
            scl_oe_q <= !scl_int;
         end
      end
   end

   // ==========================================================
   // APB: one wait state, read data latched in the first access cycle
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ready_q <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ready_q <= psel && penable && !ready_q;
         err_q   <= psel && penable && !ready_q && !mapped;
         if (rd_take)
         begin
            rdata_q <= 32'h0000_0000;
            if (hit(paddr, CTRL_ONE_OFS))
               rdata_q[7:0] <= ctrl_one_rd;
            if (hit(paddr, CTRL_TWO_OFS))
               rdata_q[7:0] <= {ctrl_two_q[7:3], ctrl_two_q[C2_TMO_SHORT], tof_q, ctrl_two_q[C2_TMO_EN]};
            if (hit(paddr, SHIFT_OFS))
               rdata_q[7:0] <= shift_q;
            if (hit(paddr, ACK_OFS))
               rdata_q[7:0] <= ack_q;
            if (hit(paddr, MODE_OFS))
               rdata_q[3:0] <= mode_q;
            if (hit(paddr, STATUS_OFS))
               rdata_q[3:0] <= status_rd;
         end
      end
   end

   // ==========================================================
   // Every port comes straight from a register
   assign prdata        = rdata_q;
   assign pready        = ready_q;
   assign pslverr       = err_q;
   assign data_line_o   = sda_o_q;
   assign data_line_oe  = sda_oe_q;
   assign clock_line_o  = scl_o_q;
   assign clock_line_oe = scl_oe_q;
   assign bus_irq       = irq_q;
endmodule : i2c_recv_wait_timeout_ctrl
`default_nettype wire

// ---- i2c_ext_pkg.sv ----
// Shared constants for the two-wire bus control extension block
package i2c_ext_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CTRL_ONE_OFS = 8'h00;
   localparam logic [7:0] CTRL_TWO_OFS = 8'h04;
   localparam logic [7:0] SHIFT_OFS    = 8'h08;
   localparam logic [7:0] ACK_OFS      = 8'h0C;
   localparam logic [7:0] MODE_OFS     = 8'h10;
   localparam logic [7:0] STATUS_OFS   = 8'h14;
   // ==========================================================
   // Field positions
   localparam int C1_STOP_IE   = 0;
   localparam int C1_WAIT_EN   = 1;
   localparam int C1_DATA_OVR  = 2;
   localparam int C1_CLK_OVR   = 3;
   localparam int C1_DATA_MON  = 4;
   localparam int C1_CLK_MON   = 5;
   localparam int C1_DIV_LO    = 6;
   localparam int C2_TMO_EN    = 0;
   localparam int C2_TMO_FLAG  = 1;
   localparam int C2_TMO_SHORT = 2;
   localparam int C2_DIV_HI    = 3;
   localparam int ACK_LEVEL  = 0;
   localparam int ACK_CLK_EN = 1;
   localparam int MD_ENABLE  = 0;
   localparam int MD_SRC_SEL = 1;
   localparam int MD_DLATCH  = 2;
   localparam int MD_CLATCH  = 3;
   localparam int ST_REQ     = 0;
   localparam int ST_BUSY    = 1;
   localparam int ST_DLEVEL  = 2;
   localparam int ST_CLEVEL  = 3;
   // ==========================================================
   // Reset values and counts
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] ACK_RST      = 8'h00;
   localparam logic [3:0] MODE_RST     = 4'hC;
   localparam logic [3:0] LAST_DATA_BIT = 4'h8;
   localparam logic [3:0] ACK_BIT       = 4'h9;
   localparam int LONG_TMO_BITS  = 16;
   localparam int SHORT_TMO_BITS = 14;
endpackage : i2c_ext_pkg

// ---- i2c_ext_if.sv ----
// Carrier between the top block, the clock divider and the time-out detector
`timescale 1ns/1ps
`default_nettype none
interface i2c_ext_if;
   logic [4:0] div_sel;     // divider_sel_b4..b0
   logic       src_sel;     // source_clock_select
   logic       run;         // Interface enabled and clocked
   logic       tick;        // One pulse per bus_system_clock cycle
   logic       tmo_en;      // timeout_enable
   logic       tmo_short;   // timeout_period_select
   logic       busy;        // bus_busy_flag
   logic       scl_high;    // Synchronised clock line is high
   logic       overflow;    // Time-out counter overflow pulse
   modport top_mp (output div_sel, src_sel, run, tmo_en, tmo_short, busy, scl_high,
                   input tick, overflow);
   modport div_mp (input div_sel, src_sel, run, output tick);
   modport tmo_mp (input run, tick, tmo_en, tmo_short, busy, scl_high, output overflow);
endinterface : i2c_ext_if
`default_nettype wire

// ---- i2c_clk_div.sv ----
// Bus system clock divider with half-step ratios
`timescale 1ns/1ps
`default_nettype none
module i2c_clk_div
(
   input  wire logic clk,
   input  wire logic srst,
   i2c_ext_if.div_mp ctl
);
   import i2c_ext_pkg::*;

   logic       half_q;   // Half-rate source phase
   logic [4:0] acc_q;    // Half-steps of source clock
   logic       tick_q;
   logic       src_en;

   // Threshold in half source cycles; code 3 and codes 20 to 31 fall back to 1/2, low bits count only below 4
   function automatic logic [4:0] ratio_x2(input logic [4:0] sel);
      case (sel[4:2])
         3'b000:  ratio_x2 = (sel[1:0] == 2'b01) ? 5'd8 : (sel[1:0] == 2'b10) ? 5'd16 : 5'd4;
         3'b001:  ratio_x2 = 5'd5;
         3'b010:  ratio_x2 = 5'd6;
         3'b011:  ratio_x2 = 5'd10;
         3'b100:  ratio_x2 = 5'd12;
         default: ratio_x2 = 5'd4;
      endcase
   endfunction : ratio_x2

   // Source is either every clock or every other one
   assign src_en = ctl.src_sel ? half_q : 1'b1;

   // ==========================================================
   // Half-rate phase
   always_ff @(posedge clk)
   begin
      if (srst || !ctl.run)
         half_q <= 1'b0;
      else
         half_q <= ~half_q;
   end

   // Accumulate two half-steps per source cycle so 2.5 needs no fractional state
   always_ff @(posedge clk)
   begin
      tick_q <= 1'b0;
      if (srst || !ctl.run)
         acc_q <= 5'd0;
      else if (src_en)
      begin
         if (acc_q + 5'd2 >= ratio_x2(ctl.div_sel))
         begin
            acc_q  <= 5'(acc_q + 5'd2 - ratio_x2(ctl.div_sel));
            tick_q <= 1'b1;
         end
         else
            acc_q <= 5'(acc_q + 5'd2);
      end
   end

   assign ctl.tick = tick_q;
endmodule : i2c_clk_div
`default_nettype wire

// ---- i2c_timeout.sv ----
// Clock-stuck-high time-out counter
`timescale 1ns/1ps
`default_nettype none
module i2c_timeout
(
   input  wire logic clk,
   input  wire logic srst,
   i2c_ext_if.tmo_mp ctl
);
   import i2c_ext_pkg::*;

   logic [LONG_TMO_BITS-1:0] cnt_q;
   logic                     ovf_q;
   logic                     top;

   // Short mode wraps at 14 bits, long mode at 16
   assign top = ctl.tmo_short ? (&cnt_q[SHORT_TMO_BITS-1:0]) : (&cnt_q);

   // ==========================================================
   // Only a continuous high period while busy is measured
   always_ff @(posedge clk)
   begin
      ovf_q <= 1'b0;
      if (srst || !ctl.run || !ctl.tmo_en || !ctl.busy || !ctl.scl_high)
         cnt_q <= '0;
      else if (ctl.tick)
      begin
         cnt_q <= cnt_q + 1'b1;
         ovf_q <= top;
      end
   end

   assign ctl.overflow = ovf_q;
endmodule : i2c_timeout
`default_nettype wire

// ---- i2c_ext_properties.sv ----
// Concurrent checks on the ports of the control extension top
`timescale 1ns/1ps
`default_nettype none
module i2c_ext_properties
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        bus_busy_flag,
   input wire logic        wait_mode,
   input wire logic        wait_clock_stop,
   input wire logic        clock_line_i,
   input wire logic        clock_line_o,
   input wire logic        clock_line_oe,
   input wire logic        data_line_oe,
   input wire logic        bus_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ==========================================
   // Byte end on a low clock, then the line is pulled low
   sequence s_byte_end;
      bus_irq && !clock_line_i;
   endsequence
   sequence s_hold;
      clock_line_oe && !clock_line_o;
   endsequence
   // Reset check runs during reset itself, so it has no disable
   a_reset_quiets: assert property (disable iff (1'b0)
      srst |=> !pready && !bus_irq && !clock_line_oe && !data_line_oe)
      else $error("outputs active after reset");
   a_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
      else $error("ready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_error_read_zero: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("error without ready or nonzero data");
   a_irq_pulse: assert property (bus_irq |=> !bus_irq)
      else $error("interrupt longer than one cycle");
   a_stall_holds: assert property (s_byte_end |-> ##[0:2] s_hold)
      else $error("clock not held after byte end");
   a_hold_lasts: assert property ($rose(clock_line_oe && !clock_line_o) |=> s_hold [*3])
      else $error("clock hold released too soon");
   a_idle_no_irq: assert property (!bus_busy_flag [*6] |-> !bus_irq)
      else $error("interrupt on a free bus");
   a_frozen_quiet: assert property ((wait_mode && wait_clock_stop) [*3] |-> !bus_irq)
      else $error("interrupt with clock stopped");
endmodule : i2c_ext_properties
bind i2c_recv_wait_timeout_ctrl i2c_ext_properties u_props
(
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_busy_flag(bus_busy_flag),
   .wait_mode(wait_mode), .wait_clock_stop(wait_clock_stop), .clock_line_i(clock_line_i),
   .clock_line_o(clock_line_o), .clock_line_oe(clock_line_oe),
   .data_line_oe(data_line_oe), .bus_irq(bus_irq)
);
`default_nettype wire

// ---- i2c_bus_partner.sv ----
// Far-side bus master model that clocks bits onto the open-drain lines
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner
(
   input  wire logic clk,
   input  wire logic scl_o,
   input  wire logic scl_oe,
   input  wire logic sda_o,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   logic scl_low_q = 1'b0;
   logic sda_low_q = 1'b0;
   int   falls = 0;
   // ==========================================
   // Pull-ups: a line is low only while someone pulls it low
   assign scl = !(scl_low_q || (scl_oe && !scl_o));
   assign sda = !(sda_low_q || (sda_oe && !sda_o));
   // Clock stands high between frames; a held-low clock is waited out
   task automatic clock_bits(input logic [8:0] b, input int n, input int half);
      logic [8:0] s;
      int         k;
      s = b;
      falls = 0;
      sda_low_q <= !s[8];
      for (int i = 0; i < n; i++)
      begin
         repeat (half) @(posedge clk);
         scl_low_q <= 1'b1;
         falls++;
         repeat (half) @(posedge clk);
         s = {s[7:0], 1'b1};
         sda_low_q <= !s[8];
         scl_low_q <= 1'b0;
         k = 0;
         do
         begin
            @(posedge clk);
            k++;
         end
         while (scl !== 1'b1 && k < 4000);
      end
      sda_low_q <= 1'b0;
   endtask : clock_bits
endmodule : i2c_bus_partner
`default_nettype wire

// ---- i2c_recv_wait_timeout_ctrl_bench.sv ----
// Self-checking bench for the two-wire bus control extension
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %s", $time, m); end end
module i2c_recv_wait_timeout_ctrl_bench;
   import i2c_ext_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready, pslverr, perr, scl, sda, dlo, dloe, clo, cloe, bus_irq;
   logic        bus_busy_flag = 1'b0;
   logic        transmit_mode = 1'b0;
   logic        address_phase = 1'b0;
   logic        wait_mode = 1'b0;
   logic        wait_clock_stop = 1'b0;
   int          n_fail = 0;
   int          checks_done = 0;
   int          n_irq = 0;
   int          m, c;
   logic [7:0]  ofs [4] = '{CTRL_ONE_OFS, CTRL_TWO_OFS, ACK_OFS, MODE_OFS};
   // Monitor bits read 1 while the disabled interface releases both lines
   logic [31:0] rv [4] = '{32'(CTRL_ONE_RST) | (32'h1 << C1_DATA_MON) | (32'h1 << C1_CLK_MON),
                           32'(CTRL_TWO_RST), 32'(ACK_RST), 32'(MODE_RST)};
   logic [4:0]  dsel [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0C, 5'h10};
   int          dtk [7] = '{60, 30, 15, 48, 40, 24, 20};
   i2c_recv_wait_timeout_ctrl u_dut
   (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_busy_flag(bus_busy_flag), .transmit_mode(transmit_mode), .address_phase(address_phase),
      .wait_mode(wait_mode), .wait_clock_stop(wait_clock_stop), .data_line_i(sda),
      .data_line_o(dlo), .data_line_oe(dloe), .clock_line_i(scl), .clock_line_o(clo),
      .clock_line_oe(cloe), .bus_irq(bus_irq)
   );
   i2c_bus_partner u_part
   (
      .clk(clk), .scl_o(clo), .scl_oe(cloe), .sda_o(dlo), .sda_oe(dloe), .scl(scl), .sda(sda)
   );
   // ==========================================
   // Clock, interrupt counter and watchdog
   initial forever #5 clk = ~clk;
   always @(posedge clk) if (bus_irq === 1'b1) n_irq <= n_irq + 1;
   // Longest wait is the short time-out, some 53k cycles in all
   initial
   begin
      repeat (80000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
   task automatic wrap_up;
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // Register access: setup, then access until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      apb(1'b0, a, 32'h0, q);
   endtask : rd
   task automatic wait_irq(input int lim, output int n);
      int s;
      s = n_irq;
      n = 0;
      while (n_irq == s && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) n_fail++;
   endtask : wait_irq
   // Bus system clock ticks over 120 cycles, once the ratio has settled
   task automatic count_ticks(output int t);
      t = 0;
      repeat (20) @(posedge clk);
      repeat (120)
      begin
         @(posedge clk);
         if (u_dut.ctl.tick === 1'b1) t++;
      end
   endtask : count_ticks
   // ==========================================
   // Scenarios
   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         rd(ofs[i], r);
         `CHK(r, rv[i], "reset value")
      end
      rd(8'h18, r);
      `CHK({perr, r}, {1'b1, 32'h0}, "unmapped read")
      // Overrides put the port latches on the pins
      wr(CTRL_ONE_OFS, 32'hC);
      wr(MODE_OFS, 32'h1);
      repeat (4) @(posedge clk);
      `CHK({scl, sda}, 2'b00, "latch not on pins")
      rd(STATUS_OFS, r);
      `CHK(r[3:2], 2'b00, "line level low")
      rd(CTRL_ONE_OFS, r);
      `CHK(r[5:2], 4'hF, "monitor idle")
      wr(MODE_OFS, 32'hD);
      repeat (4) @(posedge clk);
      rd(STATUS_OFS, r);
      `CHK(r[3:2], 2'b11, "line level high")
      // Every listed divider code, then the half-rate source at 1/6
      for (int i = 0; i < 7; i++)
      begin
         wr(CTRL_ONE_OFS, {24'h00_0000, dsel[i][1:0], 6'h00});
         wr(CTRL_TWO_OFS, {26'h000_0000, dsel[i][4:2], 3'h0});
         count_ticks(c);
         `CHK(c, dtk[i], "divider ratio")
      end
      wr(MODE_OFS, 32'hF);
      count_ticks(c);
      `CHK(c, 10, "half-rate source")
      wr(MODE_OFS, 32'hD);
      // Receive with the wait stall, clock kept in wait mode
      wait_mode <= 1'b1;
      wr(ACK_OFS, 32'h2);
      wr(CTRL_ONE_OFS, 32'h2);
      bus_busy_flag <= 1'b1;
      wr(SHIFT_OFS, 32'hA5);
      rd(CTRL_ONE_OFS, r);
      `CHK(r[1], 1'b1, "flag not set")
      m = n_irq;
      fork
         u_part.clock_bits(9'h14B, 9, 10);
         begin
            wait_irq(1000, c);
            `CHK(u_part.falls, 8, "stall irq not at bit 8")
            repeat (40) @(posedge clk);
            `CHK(scl, 1'b0, "clock not held")
            rd(STATUS_OFS, r);
            `CHK(r[0], 1'b0, "request bit")
            rd(CTRL_ONE_OFS, r);
            `CHK(r[5:4], 2'b01, "monitor in stall")
            wr(ACK_OFS, 32'h3);
            rd(CTRL_ONE_OFS, r);
            `CHK(r[1], 1'b0, "flag not cleared")
            wr(STATUS_OFS, 32'h1);
            wait_irq(1000, c);
            `CHK(n_irq - m, 2, "no ack irq")
            wr(SHIFT_OFS, 32'h00);
         end
      join
      `CHK(scl, 1'b1, "clock not released")
      // Transmit and address bytes: one irq at the ack clock only
      for (int i = 0; i < 2; i++)
      begin
         transmit_mode <= i[0];
         address_phase <= !i[0];
         bus_busy_flag <= 1'b0;
         wr(ACK_OFS, 32'h2);
         bus_busy_flag <= 1'b1;
         wr(SHIFT_OFS, 32'h5A);
         rd(CTRL_ONE_OFS, r);
         `CHK(r[1], 1'b0, "flag not gated")
         m = n_irq;
         fork
            u_part.clock_bits(9'h0B5, 9, 10);
            begin
               wait_irq(1000, c);
               `CHK(u_part.falls, 9, "irq not at ack")
               wr(SHIFT_OFS, 32'h5A);
            end
         join
         `CHK(n_irq - m, 1, "irq count")
      end
      // Clock stopped in wait mode: block frozen
      wait_clock_stop <= 1'b1;
      m = n_irq;
      u_part.clock_bits(9'h0, 9, 10);
      `CHK(n_irq, m, "irq while frozen")
      wait_clock_stop <= 1'b0;
      bus_busy_flag <= 1'b0;
      // Time-out, short mode at ratio 2; a low pulse restarts the count
      wr(CTRL_TWO_OFS, 32'h5);
      bus_busy_flag <= 1'b1;
      repeat (20000) @(posedge clk);
      u_part.clock_bits(9'h1FF, 1, 10);
      wait_irq(40000, c);
      `CHK(c > 2 * (1 << SHORT_TMO_BITS) - 40 && c < 2 * (1 << SHORT_TMO_BITS) + 20, 1'b1, "period")
      rd(CTRL_TWO_OFS, r);
      `CHK(r[1], 1'b1, "flag not set")
      wr(MODE_OFS, 32'hC);
      rd(CTRL_TWO_OFS, r);
      `CHK(r[1], 1'b0, "flag not cleared")
      bus_busy_flag <= 1'b0;
      wrap_up();
   end
endmodule : i2c_recv_wait_timeout_ctrl_bench
`default_nettype wire
